// ### rtl/spf_forwarder.sv
// serial packet forwarder: groups serial characters into packets or frames
// assumes rx bytes come from logic on the same clock and an apb master
//
// Contract
// [R01] minimum latency forwards every character at once
// [R02] no-fragment mode waits the message gap
// [R03] first satisfied packet criterion releases
// [R04] byte count reached releases, zero disables
// [R05] idle time reached releases, zero disables
// [R06] first packet mark makes packet ready
// [R07] second mark must follow first directly
// [R08] full frame buffer forwards, end search continues
// [R09] characters before start character are discarded
// [R10] second start char must follow first
// [R11] start characters kept only when enabled
// [R12] end character makes frame ready
// [R13] second end char must follow first
// [R14] forwarding rule strips, keeps, adds one/two
// [R15] custom forwarding picks packet or frame
// [R16] timers count a millisecond prescaled tick
// [R17] appended bytes awaited before forwarding
`timescale 1ns/1ps
module spf_forwarder #(
  parameter int TICK_CYCLES = spf_pkg::MS_CYCLES,
  parameter int DEPTH = spf_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire spf_pkg::spf_apb_req_t apb_req,
  output logic [spf_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial side
  input wire logic rx_valid,
  input wire logic [spf_pkg::CHAR_W-1:0] rx_data,
  // network side
  output spf_pkg::spf_out_t out,
  input wire logic out_ready
);

  localparam int AW = spf_pkg::PTR_W - 1;
  localparam int TW = $clog2(TICK_CYCLES);

  // ****************************************************************
  // apb registers
  // ****************************************************************
  spf_pkg::spf_cfg_t cfg_ff;
  logic pready_ff, pslverr_ff, ovf_ff, acc, wr_acc, hit;
  logic [spf_pkg::DATA_W-1:0] prdata_ff, rd_word;
  logic [spf_pkg::PTR_W-1:0] wr_ff, cm_ff, rd_ff, used, pend;
  spf_pkg::spf_frm_t state_ff, nxt_state;

  // one wait state: pready rises the cycle after the access phase opens
  assign acc = apb_req.psel && apb_req.penable && !pready_ff;
  assign wr_acc = apb_req.psel && apb_req.penable && pready_ff
                  && apb_req.pwrite;
  assign used = wr_ff - rd_ff;
  assign pend = wr_ff - cm_ff;

  // read mux and address decode
  always_comb begin
    rd_word = '0;
    hit = 1'b1;
    case (apb_req.paddr)
      spf_pkg::OFS_CTRL: begin
        rd_word[spf_pkg::CTL_MODE_LSB +: spf_pkg::MODE_W] = cfg_ff.mode;
        rd_word[spf_pkg::CTL_FRAME] = cfg_ff.frame_sel;
        rd_word[spf_pkg::CTL_MARK1_EN] = cfg_ff.mark1_en;
        rd_word[spf_pkg::CTL_MARK2_EN] = cfg_ff.mark2_en;
        rd_word[spf_pkg::CTL_START2_EN] = cfg_ff.start2_en;
        rd_word[spf_pkg::CTL_START_TX] = cfg_ff.start_tx;
        rd_word[spf_pkg::CTL_END2_EN] = cfg_ff.end2_en;
        rd_word[spf_pkg::CTL_FWD_LSB +: spf_pkg::MODE_W] = cfg_ff.fwd;
      end
      spf_pkg::OFS_GAP: rd_word[spf_pkg::MS_W-1:0] = cfg_ff.gap_ms;
      spf_pkg::OFS_SIZE: rd_word[spf_pkg::SIZE_W-1:0] = cfg_ff.pkt_size;
      spf_pkg::OFS_IDLE: rd_word[spf_pkg::MS_W-1:0] = cfg_ff.idle_ms;
      spf_pkg::OFS_MARKS: begin
        rd_word[spf_pkg::LANE0 +: spf_pkg::CHAR_W] = cfg_ff.packet_mark_first;
        rd_word[spf_pkg::LANE1 +: spf_pkg::CHAR_W] =
          cfg_ff.packet_mark_second;
        rd_word[spf_pkg::LANE2 +: spf_pkg::CHAR_W] = cfg_ff.start_char_first;
        rd_word[spf_pkg::LANE3 +: spf_pkg::CHAR_W] = cfg_ff.start_char_second;
      end
      spf_pkg::OFS_ENDS: begin
        rd_word[spf_pkg::LANE0 +: spf_pkg::CHAR_W] = cfg_ff.end_char_first;
        rd_word[spf_pkg::LANE1 +: spf_pkg::CHAR_W] = cfg_ff.end_char_second;
      end
      spf_pkg::OFS_STATUS: begin
        rd_word[spf_pkg::PTR_W-1:0] = used;
        rd_word[spf_pkg::STS_OVF] = ovf_ff;
        rd_word[spf_pkg::STS_IN_FRAME] = state_ff == spf_pkg::ST_FRAME;
      end
      default: hit = 1'b0;
    endcase
  end

  // bus handshake and read data, unmapped addresses answer with pslverr
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc && !hit;
      prdata_ff <= acc && !apb_req.pwrite ? rd_word : '0;
    end
  end

  // configuration writes, taken at the edge that completes the transfer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_ff <= spf_pkg::CFG_RST;
    end else if (wr_acc) begin
      case (apb_req.paddr)
        spf_pkg::OFS_CTRL: begin // R15
          cfg_ff.mode <= spf_pkg::spf_mode_t'(
            apb_req.pwdata[spf_pkg::CTL_MODE_LSB +: spf_pkg::MODE_W]);
          cfg_ff.frame_sel <= apb_req.pwdata[spf_pkg::CTL_FRAME];
          cfg_ff.mark1_en <= apb_req.pwdata[spf_pkg::CTL_MARK1_EN];
          cfg_ff.mark2_en <= apb_req.pwdata[spf_pkg::CTL_MARK2_EN];
          cfg_ff.start2_en <= apb_req.pwdata[spf_pkg::CTL_START2_EN];
          cfg_ff.start_tx <= apb_req.pwdata[spf_pkg::CTL_START_TX];
          cfg_ff.end2_en <= apb_req.pwdata[spf_pkg::CTL_END2_EN];
          cfg_ff.fwd <= spf_pkg::spf_fwd_t'(
            apb_req.pwdata[spf_pkg::CTL_FWD_LSB +: spf_pkg::MODE_W]);
        end
        spf_pkg::OFS_GAP:
          cfg_ff.gap_ms <= apb_req.pwdata[spf_pkg::MS_W-1:0];
        spf_pkg::OFS_SIZE:
          cfg_ff.pkt_size <= apb_req.pwdata[spf_pkg::SIZE_W-1:0];
        spf_pkg::OFS_IDLE:
          cfg_ff.idle_ms <= apb_req.pwdata[spf_pkg::MS_W-1:0];
        spf_pkg::OFS_MARKS: begin
          cfg_ff.packet_mark_first <=
            apb_req.pwdata[spf_pkg::LANE0 +: spf_pkg::CHAR_W];
          cfg_ff.packet_mark_second <=
            apb_req.pwdata[spf_pkg::LANE1 +: spf_pkg::CHAR_W];
          cfg_ff.start_char_first <=
            apb_req.pwdata[spf_pkg::LANE2 +: spf_pkg::CHAR_W];
          cfg_ff.start_char_second <=
            apb_req.pwdata[spf_pkg::LANE3 +: spf_pkg::CHAR_W];
        end
        spf_pkg::OFS_ENDS: begin
          cfg_ff.end_char_first <=
            apb_req.pwdata[spf_pkg::LANE0 +: spf_pkg::CHAR_W];
          cfg_ff.end_char_second <=
            apb_req.pwdata[spf_pkg::LANE1 +: spf_pkg::CHAR_W];
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // millisecond tick and timers
  // ****************************************************************
  logic [TW-1:0] presc_ff;
  logic tick_ff, gap_done, idle_done;

  // prescaler: one tick pulse per millisecond
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      presc_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= presc_ff == TW'(TICK_CYCLES - 1); // R16
      presc_ff <= presc_ff == TW'(TICK_CYCLES - 1) ? '0 : presc_ff + 1'b1;
    end
  end

  // both stopwatches restart on every received character
  spf_ms_timer #(.W(spf_pkg::MS_W)) u_gap_timer (
    .clock(clock), .rst(rst), .tick(tick_ff), .restart(rx_valid),
    .limit(cfg_ff.gap_ms), .done(gap_done));
  spf_ms_timer #(.W(spf_pkg::MS_W)) u_idle_timer (
    .clock(clock), .rst(rst), .tick(tick_ff), .restart(rx_valid),
    .limit(cfg_ff.idle_ms), .done(idle_done));

  // ****************************************************************
  // character classification
  // ****************************************************************
  logic custom, frame, mark_on, two, seen_ff, nxt_seen, done, wr_en, rew;
  logic wr_do, full_now, rel, rel_eff, ex_end, strip;
  logic [1:0] extra_ff, nxt_extra, plus;
  logic [spf_pkg::CHAR_W-1:0] mk1, mk2;
  logic [spf_pkg::PTR_W-1:0] base, nxt_wr, nxt_pend;

  assign custom = cfg_ff.mode == spf_pkg::MODE_CUSTOM;
  assign frame = custom && cfg_ff.frame_sel; // R15
  assign mk1 = frame ? cfg_ff.end_char_first : cfg_ff.packet_mark_first;
  assign mk2 = frame ? cfg_ff.end_char_second : cfg_ff.packet_mark_second;
  assign two = frame ? cfg_ff.end2_en : cfg_ff.mark2_en;
  assign mark_on = frame ? state_ff == spf_pkg::ST_FRAME : cfg_ff.mark1_en;
  assign strip = cfg_ff.fwd == spf_pkg::FWD_STRIP;
  assign plus = cfg_ff.fwd == spf_pkg::FWD_PLUS1 ? 2'd1 :
                cfg_ff.fwd == spf_pkg::FWD_PLUS2 ? 2'd2 : 2'd0; // R14

  // decides per character: store, drop, or take back a held first mark
  always_comb begin
    wr_en = 1'b0;
    rew = 1'b0;
    done = 1'b0;
    nxt_state = state_ff;
    nxt_seen = seen_ff;
    nxt_extra = extra_ff;
    if (rx_valid) begin
      if (extra_ff != 2'd0) begin
        wr_en = 1'b1; // R17
        nxt_extra = extra_ff - 2'd1;
      end else if (!custom) begin
        wr_en = 1'b1; // R01
      end else if (frame && state_ff == spf_pkg::ST_HUNT) begin
        if (rx_data == cfg_ff.start_char_first) begin // R09
          wr_en = cfg_ff.start_tx; // R11
          nxt_state = cfg_ff.start2_en ? spf_pkg::ST_START2
                                       : spf_pkg::ST_FRAME;
        end
      end else if (frame && state_ff == spf_pkg::ST_START2) begin
        if (rx_data == cfg_ff.start_char_second) begin // R10
          wr_en = cfg_ff.start_tx; // R11
          nxt_state = spf_pkg::ST_FRAME;
        end else if (rx_data == cfg_ff.start_char_first) begin
          rew = cfg_ff.start_tx;
          wr_en = cfg_ff.start_tx;
        end else begin
          rew = cfg_ff.start_tx; // R10
          nxt_state = spf_pkg::ST_HUNT;
        end
      end else if (mark_on) begin
        wr_en = 1'b1;
        done = two ? seen_ff && rx_data == mk2 : rx_data == mk1; // R06 R12
        nxt_seen = two && !done && rx_data == mk1; // R07 R13
        if (done && strip) begin
          wr_en = 1'b0; // R14
          rew = two;
        end
      end else begin
        wr_en = 1'b1;
      end
    end
    if (done) begin
      nxt_extra = plus; // R17
      if (frame) begin
        nxt_state = spf_pkg::ST_HUNT;
      end
    end
    if (pend == '0) begin
      rew = 1'b0;
    end
  end

  assign base = wr_ff - spf_pkg::PTR_W'(rew);
  assign full_now = base - rd_ff == spf_pkg::DEPTH_CNT;
  assign wr_do = wr_en && !full_now;
  assign nxt_wr = base + spf_pkg::PTR_W'(wr_do);
  assign nxt_pend = nxt_wr - cm_ff;
  assign ex_end = rx_valid && extra_ff == 2'd1;

  // release decision: whichever enabled criterion is met first
  always_comb begin
    case (cfg_ff.mode)
      spf_pkg::MODE_MIN_LATENCY, spf_pkg::MODE_THROUGHPUT:
        rel = wr_do; // R01
      spf_pkg::MODE_NO_FRAG:
        rel = gap_done && !rx_valid; // R02
      spf_pkg::MODE_CUSTOM: begin
        rel = (done && plus == 2'd0) || ex_end; // R03 R12 R17
        if (!frame) begin
          rel = rel || (cfg_ff.pkt_size != '0
                        && nxt_pend >= cfg_ff.pkt_size) // R04
                    || (cfg_ff.idle_ms != '0 && idle_done
                        && !rx_valid); // R05
        end
      end
      default: rel = 1'b0;
    endcase
    rel = rel || nxt_pend == spf_pkg::DEPTH_CNT; // R08
  end
  assign rel_eff = rel && nxt_wr != cm_ff;

  // ****************************************************************
  // buffer and pointers
  // ****************************************************************
  logic [spf_pkg::CHAR_W-1:0] mem [DEPTH];
  logic last_mem [DEPTH];
  logic load;

  assign load = (!out.valid || out_ready) && rd_ff != cm_ff;

  // data store; the last flag of a released packet is set after the clear
  always_ff @(posedge clock) begin
    if (wr_do) begin
      mem[base[AW-1:0]] <= rx_data;
      last_mem[base[AW-1:0]] <= 1'b0;
    end
    if (rel_eff) begin
      last_mem[AW'(nxt_wr - 1'b1)] <= 1'b1;
    end
  end

  // pointers, framing state and the sticky overflow flag (set wins)
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ff <= '0;
      cm_ff <= '0;
      rd_ff <= '0;
      state_ff <= spf_pkg::ST_HUNT;
      seen_ff <= 1'b0;
      extra_ff <= 2'd0;
      ovf_ff <= 1'b0;
    end else begin
      wr_ff <= nxt_wr;
      if (rel_eff) begin
        cm_ff <= nxt_wr; // R03
      end
      if (load) begin
        rd_ff <= rd_ff + 1'b1;
      end
      state_ff <= frame ? nxt_state : spf_pkg::ST_HUNT;
      seen_ff <= custom ? nxt_seen : 1'b0;
      extra_ff <= nxt_extra;
      if (wr_en && full_now) begin
        ovf_ff <= 1'b1;
      end else if (wr_acc && apb_req.paddr == spf_pkg::OFS_STATUS
                   && apb_req.pwdata[spf_pkg::STS_OVF]) begin
        ovf_ff <= 1'b0;
      end
    end
  end

  // output stage holds its byte until the consumer takes it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out <= '0;
    end else if (load) begin
      out.valid <= 1'b1;
      out.data <= mem[rd_ff[AW-1:0]];
      out.last <= last_mem[rd_ff[AW-1:0]];
    end else if (out_ready) begin
      out.valid <= 1'b0;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_minlat_commit: assert property (@(posedge clock) disable iff (rst) // R01
    cfg_ff.mode == spf_pkg::MODE_MIN_LATENCY && wr_do |=> cm_ff == wr_ff)
    else $error("min latency byte not committed");
  a_nofrag_hold: assert property (@(posedge clock) disable iff (rst) // R02
    cfg_ff.mode == spf_pkg::MODE_NO_FRAG && !gap_done
    && nxt_pend != spf_pkg::DEPTH_CNT |=> $stable(cm_ff))
    else $error("released before message gap");
  a_rel_commit: assert property (@(posedge clock) disable iff (rst) // R03
    rel_eff |=> cm_ff == $past(nxt_wr))
    else $error("release did not commit pending data");
  a_size_hit: assert property (@(posedge clock) disable iff (rst) // R04
    custom && !frame && cfg_ff.pkt_size != '0 && pend < cfg_ff.pkt_size
    && nxt_pend >= cfg_ff.pkt_size |=> pend == '0)
    else $error("size criterion missed");
  a_hunt_drop: assert property (@(posedge clock) disable iff (rst) // R09
    frame && state_ff == spf_pkg::ST_HUNT && extra_ff == 2'd0 && rx_valid
    && rx_data != cfg_ff.start_char_first |=> wr_ff == $past(wr_ff))
    else $error("byte stored before start character");
  a_start_strip: assert property (@(posedge clock) disable iff (rst) // R11
    frame && state_ff == spf_pkg::ST_HUNT && extra_ff == 2'd0 && rx_valid
    && !cfg_ff.start_tx && pend == '0 |=> wr_ff == $past(wr_ff))
    else $error("start character stored while stripping");
  a_start2_miss: assert property (@(posedge clock) disable iff (rst) // R10
    frame && state_ff == spf_pkg::ST_START2 && rx_valid && extra_ff == 2'd0
    && rx_data != cfg_ff.start_char_second
    && rx_data != cfg_ff.start_char_first
    |=> state_ff == spf_pkg::ST_HUNT)
    else $error("start search not resumed");
  a_extra_wait: assert property (@(posedge clock) disable iff (rst) // R17
    frame && extra_ff != 2'd0 && !rx_valid
    && pend != spf_pkg::DEPTH_CNT |=> $stable(cm_ff))
    else $error("frame forwarded before appended bytes");
  a_full_flush: assert property (@(posedge clock) disable iff (rst) // R08
    nxt_pend == spf_pkg::DEPTH_CNT |=> pend == '0)
    else $error("full buffer not forwarded");

endmodule : spf_forwarder

// ### rtl/spf_ms_timer.sv
// millisecond stopwatch with a programmable limit
// assumes a one-cycle tick pulse per millisecond from the same clock
`timescale 1ns/1ps
module spf_ms_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic tick,
  input wire logic restart,
  input wire logic [W-1:0] limit,
  // status
  output logic done
);

  logic [W-1:0] cnt_ff;

  // counts ticks since restart, saturating so a long quiet spell stays done
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (restart) begin
      cnt_ff <= '0; // R16
    end else if (tick && cnt_ff != '1) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign done = cnt_ff >= limit;

  a_timer_restart: assert property (@(posedge clock) disable iff (rst)
    restart |=> cnt_ff == '0) // R16
    else $error("timer did not restart");

endmodule : spf_ms_timer

// ### rtl/spf_pkg.sv
// constants, types and register map of the serial packet forwarder
// assumes one 250 MHz clock and an apb master with 32-bit data
package spf_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  // one millisecond, rounded up to whole clock cycles
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int BUF_DEPTH = 1024;
  localparam int PTR_W = 11;
  localparam int CHAR_W = 8;
  localparam int MS_W = 16;
  localparam int SIZE_W = 11;
  localparam int MODE_W = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [PTR_W-1:0] DEPTH_CNT = 11'h0400;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_GAP = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SIZE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IDLE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MARKS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ENDS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  // control fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_FRAME = 2;
  localparam int CTL_MARK1_EN = 3;
  localparam int CTL_MARK2_EN = 4;
  localparam int CTL_START2_EN = 5;
  localparam int CTL_START_TX = 6;
  localparam int CTL_END2_EN = 7;
  localparam int CTL_FWD_LSB = 8;
  // character lanes of the marks and ends registers
  localparam int LANE0 = 0;
  localparam int LANE1 = 8;
  localparam int LANE2 = 16;
  localparam int LANE3 = 24;
  // status fields, fill level sits in the low bits
  localparam int STS_OVF = 16;
  localparam int STS_IN_FRAME = 17;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [MODE_W-1:0] {
    MODE_MIN_LATENCY, MODE_THROUGHPUT, MODE_NO_FRAG, MODE_CUSTOM
  } spf_mode_t;
  typedef enum logic [MODE_W-1:0] {
    FWD_STRIP, FWD_TRIG, FWD_PLUS1, FWD_PLUS2
  } spf_fwd_t;
  typedef enum {ST_HUNT, ST_START2, ST_FRAME} spf_frm_t;

  typedef struct packed {
    spf_mode_t mode;
    logic frame_sel;
    logic mark1_en;
    logic mark2_en;
    logic start2_en;
    logic start_tx;
    logic end2_en;
    spf_fwd_t fwd;
    logic [MS_W-1:0] gap_ms;
    logic [SIZE_W-1:0] pkt_size;
    logic [MS_W-1:0] idle_ms;
    logic [CHAR_W-1:0] packet_mark_first;
    logic [CHAR_W-1:0] packet_mark_second;
    logic [CHAR_W-1:0] start_char_first;
    logic [CHAR_W-1:0] start_char_second;
    logic [CHAR_W-1:0] end_char_first;
    logic [CHAR_W-1:0] end_char_second;
  } spf_cfg_t;

  localparam spf_cfg_t CFG_RST = '{
    mode: MODE_MIN_LATENCY, frame_sel: 1'b0, mark1_en: 1'b0,
    mark2_en: 1'b0, start2_en: 1'b0, start_tx: 1'b0, end2_en: 1'b0,
    fwd: FWD_TRIG, gap_ms: 16'h00fa, pkt_size: 11'h000,
    idle_ms: 16'h0000, packet_mark_first: 8'h00,
    packet_mark_second: 8'h00, start_char_first: 8'h00,
    start_char_second: 8'h00, end_char_first: 8'h00,
    end_char_second: 8'h00};

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } spf_apb_req_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [CHAR_W-1:0] data;
  } spf_out_t;

endpackage : spf_pkg

// ### tb/spf_serial_partner.sv
// serial device feeding the forwarder and a network consumer behind it
// assumes the same clock as the forwarder; the bench calls send()
`timescale 1ns/1ps
module spf_serial_partner (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // serial side
  output logic rx_valid,
  output logic [spf_pkg::CHAR_W-1:0] rx_data,
  // network side
  input wire spf_pkg::spf_out_t out,
  output logic out_ready,
  // bench control
  input wire logic slow
);
  logic [8:0] got [$];
  logic phase_ff;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end

  // characters back to back, one per edge, first byte in the top lane
  task automatic send(input logic [63:0] seq, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data <= seq[63-8*i -: 8];
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data; // idle line must not look like a stale character
  endtask : send

  // slow consumer takes a byte only every other cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= ~phase_ff;
    end
  end
  assign out_ready = !slow | phase_ff;

  // collect {last, data} of every byte taken
  always @(posedge clock) begin
    if (!rst && out.valid === 1'b1 && out_ready) begin
      got.push_back({out.last, out.data});
    end
  end
endmodule : spf_serial_partner

// ### tb/tb.sv
// self-checking bench of the serial packet forwarder
// assumes the partner model in spf_serial_partner and a 4-cycle tick
`timescale 1ns/1ps
module tb;
  // ****************************************************************
  // set-up
  // ****************************************************************
  typedef struct {
    logic [15:0] ctrl;
    logic [15:0] tmr;
    logic [10:0] size;
    int n;
    logic [63:0] b;
    logic [7:0] l;
    logic slow;
  } spf_row_t;
  localparam logic [63:0] SEQ = 64'h117e_225a_7f33_4400;
  // one shared stream; each row gives its own expected grouping of it, some rows alike
  spf_row_t rows [13] = '{
    '{16'h0100, 16'h0000, 11'h000, 7, SEQ, 8'hfe, 1'b1}, // min latency
    '{16'h000b, 16'h0000, 11'h000, 3, 64'h117e_2200_0000_0000, 8'h20, 0},
    '{16'h010b, 16'h0000, 11'h000, 4, 64'h117e_225a_0000_0000, 8'h10, 0},
    '{16'h020b, 16'h0000, 11'h000, 5, 64'h117e_225a_7f00_0000, 8'h08, 0},
    '{16'h030b, 16'h0000, 11'h000, 6, 64'h117e_225a_7f33_0000, 8'h04, 1},
    '{16'h011b, 16'h0000, 11'h000, 5, 64'h117e_225a_7f00_0000, 8'h08, 0},
    '{16'h0107, 16'h0000, 11'h000, 3, 64'h225a_7f00_0000_0000, 8'h20, 0},
    '{16'h0147, 16'h0000, 11'h000, 4, 64'h7e22_5a7f_0000_0000, 8'h10, 0},
    '{16'h0007, 16'h0000, 11'h000, 2, 64'h225a_0000_0000_0000, 8'h40, 0},
    '{16'h0127, 16'h0000, 11'h000, 2, 64'h5a7f_0000_0000_0000, 8'h40, 0},
    '{16'h0103, 16'h0000, 11'h003, 6, 64'h117e_225a_7f33_0000, 8'h24, 0},
    '{16'h0103, 16'h0002, 11'h000, 7, SEQ, 8'h02, 0}, // idle close
    '{16'h0102, 16'h0002, 11'h000, 7, SEQ, 8'h02, 0}}; // gap close
  logic clock;
  logic rst;
  logic slow;
  logic rx_valid;
  logic [7:0] rx_data;
  logic out_ready;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic err;
  spf_pkg::spf_apb_req_t req;
  spf_pkg::spf_out_t out;
  int fail_count;
  int checked;
  int cycles;

  spf_forwarder #(.TICK_CYCLES(4), .DEPTH(1024)) dut (.clock(clock),
    .rst(rst), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .out(out), .out_ready(out_ready));
  spf_serial_partner partner (.clock(clock), .rst(rst),
    .rx_valid(rx_valid), .rx_data(rx_data), .out(out),
    .out_ready(out_ready), .slow(slow));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // apb transfer; request held until pready is sampled high
  // no local wait limit: only the hang guard ends a stuck transfer
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
    @(posedge clock);
  endtask : apb

  task automatic reset_dut();
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
  endtask : reset_dut

  task automatic results();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // hang guard, about three times the run with every row's wait at its 400-cycle cap
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    slow = 1'b0;
    req = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    foreach (rows[k]) begin
      reset_dut();
      partner.got.delete();
      slow <= rows[k].slow;
      apb(1'b1, spf_pkg::OFS_CTRL, {16'h0000, rows[k].ctrl});
      apb(1'b1, spf_pkg::OFS_GAP, {16'h0000, rows[k].tmr});
      apb(1'b1, spf_pkg::OFS_IDLE, {16'h0000, rows[k].tmr});
      apb(1'b1, spf_pkg::OFS_SIZE, {21'h0, rows[k].size});
      apb(1'b1, spf_pkg::OFS_MARKS, 32'h227e_7f5a);
      apb(1'b1, spf_pkg::OFS_ENDS, 32'h0000_007f);
      partner.send(SEQ, 7);
      for (int w = 0; w < 400 && partner.got.size() < rows[k].n; w++) begin
        @(posedge clock);
      end
      repeat (20) @(posedge clock); // nothing further may leak out
      check("count", 32'(partner.got.size()), 32'(rows[k].n));
      for (int i = 0; i < rows[k].n; i++) begin
        check("byte", {23'h0, partner.got[i]}, {23'h0, rows[k].l[7-i],
          rows[k].b[63-8*i -: 8]});
      end
    end
    // register defaults and an unmapped place after a fresh reset
    reset_dut();
    apb(1'b0, spf_pkg::OFS_CTRL, 32'h0000_0000);
    check("ctrl", rd, 32'h0000_0100);
    apb(1'b0, spf_pkg::OFS_GAP, 32'h0000_0000);
    check("gap", rd, 32'h0000_00fa);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    check("unmapped", {31'h0, err}, 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    apb(1'b0, spf_pkg::OFS_STATUS, 32'h0000_0000);
    check("status", rd, 32'h0000_0000);
    check("status err", {31'h0, err}, 32'h0000_0000);
    results();
  end
endmodule : tb
